// ==== acb_adc_control.sv ====
`timescale 1ns/10ps
module acb_adc_control
	import acb_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic din,
	input wire logic cmp_in,
	output logic track_q,
	output logic converting_q,
	output logic [4:0] mux_pos_q,
	output logic [4:0] mux_neg_q,
	output logic polarity_select_q,
	output logic [1:0] mode_q,
	output logic [RES_BITS-1:0] dac_code_q,
	output logic [RES_BITS-1:0] result_q,
	output logic result_valid_q
);

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SHIFT,
		ST_CONV
	} acb_state_e;

	logic [2:0] cs_sync_q, sclk_sync_q, din_sync_q;
	logic cs_low, sclk_rise, sclk_fall;
	acb_state_e state_q;
	logic [CW_BITS-1:0] shift_q;
	logic [3:0] bit_cnt_q;
	logic [3:0] sar_step_q;
	logic [RES_BITS-1:0] sar_q;
	acb_ctrl_s ctrl_q;
	logic latch_d;
	acb_mux_s mux_d;

	// Channel decode, shared by both input configurations
	function automatic logic [4:0] chan_onehot(input logic [2:0] sel);
		logic [4:0] r;
		r = MUX_NONE;
		unique case (sel)
			SEL_001: r[0] = 1'b1;
			SEL_101: r[1] = 1'b1;
			SEL_010: r[2] = 1'b1;
			SEL_110: r[3] = 1'b1;
			default: r = MUX_NONE;
		endcase
		return r;
	endfunction

	// Partner of a channel inside its fixed pair
	function automatic logic [4:0] pair_of(input logic [4:0] ch);
		return {1'b0, ch[2], ch[3], ch[0], ch[1]};
	endfunction

	// Two flops on each link pin, not on cmp_in; a third stage gives edge history
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			cs_sync_q <= 3'h7;
			sclk_sync_q <= 3'h0;
			din_sync_q <= 3'h0;
		end
		else
		begin
			cs_sync_q <= {cs_sync_q[1:0], cs_n};
			sclk_sync_q <= {sclk_sync_q[1:0], sclk};
			din_sync_q <= {din_sync_q[1:0], din};
		end
	end

	// Edges judged only on synchronised stages, never stage one
	assign cs_low = ~cs_sync_q[1];
	assign sclk_rise = sclk_sync_q[1] & ~sclk_sync_q[2];
	assign sclk_fall = ~sclk_sync_q[1] & sclk_sync_q[2];

	// Word complete when the eighth bit is in and sclk falls; a select
	// released on that same fall cancels the word, or hold would stick
	assign latch_d = (state_q == ST_SHIFT) && cs_low && sclk_fall
		&& (bit_cnt_q == HOLD_AT_BIT);

	// Mux steering from the incoming word
	always_comb
	begin
		mux_d.pos_sel = chan_onehot(shift_q[POS_SEL_HI:POS_SEL_LO]);
		mux_d.neg_sel = MUX_NONE;
		if (shift_q[POS_CONFIG])
			mux_d.neg_sel[MUX_COMMON] = 1'b1;
		else
			mux_d.neg_sel = pair_of(mux_d.pos_sel);
	end

	// Framing state; a select toggle aborts a running conversion
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
			state_q <= ST_IDLE;
		else
		begin
			unique case (state_q)
				ST_IDLE:
					if (cs_low && sclk_rise && din_sync_q[1])
						state_q <= ST_SHIFT;
				ST_SHIFT:
					if (!cs_low)
						state_q <= ST_IDLE;
					else if (latch_d)
						state_q <= ST_CONV;
				ST_CONV:
					if (!cs_low || sar_step_q == SAR_STEPS)
						state_q <= ST_IDLE;
			endcase
		end
	end

	// Shift register and bit counter, sampled on sclk rise
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			shift_q <= '0;
			bit_cnt_q <= BIT_CNT_ZERO;
		end
		else if (state_q == ST_IDLE)
		begin
			shift_q <= {{(CW_BITS-1){1'b0}}, 1'b1};
			bit_cnt_q <= 4'h1; // Start bit counts as bit one
		end
		else if (state_q == ST_SHIFT && cs_low && sclk_rise && bit_cnt_q < HOLD_AT_BIT)
		begin
			shift_q <= {shift_q[CW_BITS-2:0], din_sync_q[1]};
			bit_cnt_q <= bit_cnt_q + 4'h1;
		end
	end

	// Latch whole word before acting on any field
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			ctrl_q <= '0;
			mux_pos_q <= MUX_NONE;
			mux_neg_q <= MUX_NONE;
			polarity_select_q <= 1'b0;
			mode_q <= MODE_FULL_PD;
		end
		else if (latch_d)
		begin
			ctrl_q.chan_sel <= shift_q[POS_SEL_HI:POS_SEL_LO];
			ctrl_q.polarity_select <= shift_q[POS_POLARITY];
			ctrl_q.input_config_select <= shift_q[POS_CONFIG];
			ctrl_q.mode_field_hi <= shift_q[POS_MODE_HI];
			ctrl_q.mode_field_lo <= shift_q[POS_MODE_LO];
			mux_pos_q <= mux_d.pos_sel;
			mux_neg_q <= mux_d.neg_sel;
			polarity_select_q <= shift_q[POS_POLARITY];
			mode_q <= shift_q[POS_MODE_HI:POS_MODE_LO];
		end
	end

	// Track after fifth bit, hold after eighth; reconnect at end
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
			track_q <= 1'b1;
		else if (state_q == ST_SHIFT && sclk_fall && bit_cnt_q == TRACK_AT_BIT)
			track_q <= 1'b1;
		else if (latch_d)
			track_q <= 1'b0; // relies on host spacing
		else if (state_q == ST_CONV && (sar_step_q == SAR_STEPS || !cs_low))
			track_q <= 1'b1;
	end

	// SAR: one decision per core cycle; comparator high keeps trial
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			sar_step_q <= 4'h0;
			sar_q <= '0;
			dac_code_q <= '0;
			converting_q <= 1'b0;
		end
		else if (latch_d)
		begin
			sar_step_q <= 4'h0;
			sar_q <= '0;
			dac_code_q <= {1'b1, {(RES_BITS-1){1'b0}}};
			converting_q <= 1'b1;
		end
		else if (state_q == ST_CONV && sar_step_q < SAR_STEPS)
		begin
			// Keep or drop the trial bit, then try the next lower one
			sar_q <= dac_code_q & ~(cmp_in ? '0 : (dac_code_q & ~sar_q));
			dac_code_q <= (dac_code_q & ~(cmp_in ? '0 : (dac_code_q & ~sar_q)))
				| ({1'b0, dac_code_q[RES_BITS-1:1]} & ~{1'b0, sar_q[RES_BITS-1:1]}
				& {RES_BITS{sar_step_q != SAR_STEPS - 4'h1}});
			sar_step_q <= sar_step_q + 4'h1;
		end
		else
			converting_q <= 1'b0;
	end

	// Bipolar result is two's complement: flip MSB of offset code
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			result_q <= '0;
			result_valid_q <= 1'b0;
		end
		else if (state_q == ST_CONV && sar_step_q == SAR_STEPS)
		begin
			result_q <= ctrl_q.polarity_select ? sar_q
				: {~sar_q[RES_BITS-1], sar_q[RES_BITS-2:0]};
			result_valid_q <= 1'b1; // Level until next word latches
		end
		else if (latch_d)
			result_valid_q <= 1'b0;
	end

endmodule

// ==== acb_pkg.sv ====
package acb_pkg;

	// Control word layout
	localparam int CW_BITS = 8;
	localparam int POS_START = 7;
	localparam int POS_SEL_HI = 6;
	localparam int POS_SEL_LO = 4;
	localparam int POS_POLARITY = 3;
	localparam int POS_CONFIG = 2;
	localparam int POS_MODE_HI = 1;
	localparam int POS_MODE_LO = 0;

	// Bit counts at which track and hold change
	localparam logic [3:0] TRACK_AT_BIT = 4'h5;
	localparam logic [3:0] HOLD_AT_BIT = 4'h8;
	localparam logic [3:0] BIT_CNT_ZERO = 4'h0;

	// Result size
	localparam int RES_BITS = 10;
	localparam logic [3:0] SAR_STEPS = 4'hA;

	// Timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int ACQ_MIN_NS = 1500;
	localparam int ACQ_MIN_CYC = (ACQ_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Channel select codes
	localparam logic [2:0] SEL_001 = 3'h1;
	localparam logic [2:0] SEL_101 = 3'h5;
	localparam logic [2:0] SEL_010 = 3'h2;
	localparam logic [2:0] SEL_110 = 3'h6;

	// Mode field codes
	localparam logic [1:0] MODE_FULL_PD = 2'h0;
	localparam logic [1:0] MODE_FAST_PD = 2'h1;
	localparam logic [1:0] MODE_INT_CLK = 2'h2;
	localparam logic [1:0] MODE_EXT_CLK = 2'h3;

	// Mux one-hot: bits 0..3 are channels, bit 4 is the common return
	localparam logic [4:0] MUX_NONE = 5'h00;
	localparam int MUX_COMMON = 4;

	typedef enum logic [1:0] {
		MODE_E_FULL_PD,
		MODE_E_FAST_PD,
		MODE_E_INT_CLK,
		MODE_E_EXT_CLK
	} acb_mode_e;

	// Latched control word fields
	typedef struct packed {
		logic [2:0] chan_sel;
		logic polarity_select;
		logic input_config_select;
		logic mode_field_hi;
		logic mode_field_lo;
	} acb_ctrl_s;

	// Multiplexer steering
	typedef struct packed {
		logic [4:0] pos_sel;
		logic [4:0] neg_sel;
	} acb_mux_s;

endpackage

// ==== acb_host.sv ====
`timescale 1ns/10ps
// Host master; link clock idles low outside frames
module acb_host
(
	output logic cs_n,
	output logic sclk,
	output logic din
);
	initial
	begin
		cs_n = 1'b1;
		sclk = 1'b0;
		din = 1'b0;
	end
	// Data set while low, taken on the rising edge
	task automatic put(input logic b);
		din = b;
		#400 sclk = 1'b1;
		#400 sclk = 1'b0;
	endtask
	// Zeros first, then top n bits; 2.4 us from fifth to last fall
	task automatic send(input logic [7:0] w, input int lead, input int n);
		#37 cs_n = 1'b0;
		repeat (lead) put(1'b0);
		for (int i = 7; i > 7 - n; i--)
			put(w[i]);
	endtask
	// Released data line must not keep its last value
	task automatic stop();
		cs_n = 1'b1;
		din = ~din;
		#400;
	endtask
endmodule

// ==== acb_adc_control_props.sv ====
`timescale 1ns/10ps
module acb_adc_control_props
	import acb_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic din,
	input wire logic cmp_in,
	input wire logic track_q,
	input wire logic converting_q,
	input wire logic [4:0] mux_pos_q,
	input wire logic [4:0] mux_neg_q,
	input wire logic polarity_select_q,
	input wire logic [1:0] mode_q,
	input wire logic [RES_BITS-1:0] dac_code_q,
	input wire logic [RES_BITS-1:0] result_q,
	input wire logic result_valid_q
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	// A conversion that the host lets run, since select high aborts it
	sequence conv_kept;
		$rose(converting_q) ##1 (!cs_n)[*7];
	endsequence
	hold_at_start_a: assert property ($rose(converting_q) |-> !track_q)
		else $error("still tracking at start");
	conv_length_a: assert property (conv_kept |-> converting_q)
		else $error("conversion cut short");
	done_track_a: assert property ($fell(converting_q) |-> track_q)
		else $error("no tracking after end");
	idle_track_a: assert property
		(!converting_q && !$past(converting_q) |-> track_q)
		else $error("held while idle");
	diff_pair_a: assert property
		(mux_neg_q != MUX_NONE && !mux_neg_q[4]
		|-> (mux_pos_q | mux_neg_q) inside {5'h03, 5'h0C})
		else $error("bad pair");
	single_end_a: assert property
		(mux_neg_q[4] |-> mux_neg_q == 5'h10 &&
		mux_pos_q inside {5'h00, 5'h01, 5'h02, 5'h04, 5'h08})
		else $error("bad single route");
	result_keep_a: assert property
		(result_valid_q && $past(result_valid_q) |-> $stable(result_q))
		else $error("result moved");
	word_keep_a: assert property
		(converting_q && $past(converting_q)
		|-> $stable({mux_pos_q, mode_q, polarity_select_q}))
		else $error("word moved");
	// Two sync stages, one state step, then the flop: five samples
	abort_idle_a: assert property (cs_n[*5] |-> !converting_q)
		else $error("runs with select high");
endmodule
bind acb_adc_control acb_adc_control_props u_props (.core_clk, .reset,
	.cs_n, .sclk, .din, .cmp_in, .track_q, .converting_q, .mux_pos_q,
	.mux_neg_q, .polarity_select_q, .mode_q, .dac_code_q, .result_q,
	.result_valid_q);

// ==== acb_adc_control_tb.sv ====
`timescale 1ns/10ps
`define CHK(a, b) \
	begin \
		checked++; \
		if ((a) !== (b)) \
		begin \
			mismatches++; \
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); \
		end \
	end
module acb_adc_control_tb;
	import acb_pkg::*;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic cmp_in = 1'b0;
	logic cs_n, sclk, din, track_q, converting_q, seen;
	logic polarity_select_q, result_valid_q;
	logic [4:0] mux_pos_q, mux_neg_q;
	logic [1:0] mode_q;
	logic [RES_BITS-1:0] dac_code_q, result_q;
	int mismatches = 0;
	int checked = 0;
	int k;
	// Word, expected positive and negative one-hot routes
	logic [17:0] rows [9] = '{{8'h9C, 5'h01, 5'h10},
		{8'hD5, 5'h02, 5'h10}, {8'hAE, 5'h04, 5'h10},
		{8'hE7, 5'h08, 5'h10}, {8'h93, 5'h01, 5'h02},
		{8'hAA, 5'h04, 5'h08}, {8'hD1, 5'h02, 5'h01},
		{8'hE8, 5'h08, 5'h04}, {8'h8C, 5'h00, 5'h10}};
	acb_adc_control u_dut (.core_clk, .reset, .cs_n, .sclk, .din, .cmp_in,
		.track_q, .converting_q, .mux_pos_q, .mux_neg_q, .polarity_select_q,
		.mode_q, .dac_code_q, .result_q, .result_valid_q);
	acb_host u_host (.cs_n, .sclk, .din);
	// 10 MHz core clock
	initial
	begin
		forever #50 core_clk = ~core_clk;
	end
	task automatic report_and_stop();
		$display("checked=%0d mismatches=%0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Bounded wait for a start, and for its end when full is set
	task automatic wait_conv(input bit full);
		seen = 1'b0;
		k = 0;
		while (!(seen && (!full || result_valid_q === 1'b1)) && k < 200)
		begin
			@(negedge core_clk);
			if (converting_q === 1'b1)
				seen = 1'b1;
			k++;
		end
		`CHK(k < 200, 1'b1)
	endtask
	initial
	begin
		repeat (16) @(posedge core_clk);
		reset <= 1'b0;
		@(negedge core_clk);
		`CHK(track_q, 1'b1)
		`CHK(result_valid_q, 1'b0)
		// Odd rows keep every trial bit, even rows drop them all
		for (int i = 0; i < 9; i++)
		begin
			@(posedge core_clk);
			cmp_in <= i[0];
			u_host.send(rows[i][17:10], i % 3, 8);
			wait_conv(1'b1);
			`CHK(mux_pos_q, rows[i][9:5])
			`CHK(mux_neg_q, rows[i][4:0])
			`CHK(polarity_select_q, rows[i][13])
			`CHK(mode_q, rows[i][11:10])
			`CHK(result_q, {10{i[0]}} ^ {~rows[i][13], 9'h000})
			u_host.stop();
		end
		// Half a word then release: nothing may be latched
		u_host.send(8'hE7, 0, 4);
		u_host.stop();
		repeat (8) @(negedge core_clk);
		`CHK(converting_q, 1'b0)
		`CHK(mux_pos_q, 5'h00)
		// Select released on the very last fall: the word is dropped
		u_host.send(8'h9C, 0, 8);
		u_host.stop();
		repeat (8) @(negedge core_clk);
		`CHK(track_q, 1'b1)
		`CHK(mux_pos_q, 5'h00)
		// Release in mid-conversion, then a word with leading zeros
		u_host.send(8'hAE, 0, 8);
		wait_conv(1'b0);
		u_host.stop();
		repeat (8) @(negedge core_clk);
		`CHK(track_q, 1'b1)
		`CHK(result_valid_q, 1'b0)
		u_host.send(8'h9C, 2, 8);
		wait_conv(1'b1);
		`CHK(mux_pos_q, 5'h01)
		report_and_stop();
	end
	// Run should take some 115 us
	initial
	begin
		#2000000;
		mismatches++;
		report_and_stop();
	end
endmodule
